// file: hw/image_sensor_exposure_sequencer.sv
/*
 * exposure and readout sequencer of a global-shutter image sensor, with a
 * small shift-register buffer in the pixel path.
 * assumes all inputs are synchronous to clk_i, settings stay stable while
 * used, and the receiver may stall the pixel stream with pixel_ready_i.
 */
//
// Contract
// - master mode fires events on threshold equality
// - pixel reset held until reset length reached
// - dual/triple slope reset pulse of fixed length
// - frame transfer threshold starts overhead period
// - line counter loads one after reset, overhead
// - subsampling steps two, starts at two
// - indicators high from reset fall to sample fall
// - sample pulse at transfer, one tick longer
// - slave mode ignores thresholds, pins active low
// - slave pins decode pixel and extra resets
// - all pins low starts frame transfer
// - nondestructive bit suppresses internal reset pulses
// - row-wise readout with line and frame valid
// - master drops frame-valid after 480 lines
// - slave reads from start row until transfer
// - past last row frame-valid stays, lines toggle
// - first core tick on second edge after release
// - reset restarts sequencer, keeps settings
// - sequencer runs on input clock divided four; the code steps on every input clock and core_en is unused
// - mode bit picks master or slave exposure
// - frame overhead, row overhead, kernels of four

// shift-register fifo: the head slot is always a flop, so outputs are
// registered; a word enters behind the last valid slot after the shift
module pixel_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // slot 0 is the head
        logic [DEPTH-1:0]            vld; // slot occupancy
    } fifo_s;

    fifo_s fifo_reg;  // registered state
    fifo_s fifo_next; // next state

    // shift on pop, then place the pushed word in the first free slot
    always_comb begin
        logic pop;
        logic placed;
        pop = fifo_reg.vld[0] && out_ready_i;
        placed = 1'b0;
        fifo_next = fifo_reg;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                fifo_next.mem[i] = fifo_reg.mem[i+1];
                fifo_next.vld[i] = fifo_reg.vld[i+1];
            end
            fifo_next.vld[DEPTH-1] = 1'b0;
        end
        // full is judged on the old state: a pop and push in the same
        // cycle at full is refused, trading a little rate for a flop ready
        if (in_valid_i && !fifo_reg.vld[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!placed && !fifo_next.vld[i]) begin
                    fifo_next.mem[i] = in_data_i;
                    fifo_next.vld[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

    assign in_ready_o  = !fifo_reg.vld[DEPTH-1];
    assign out_valid_o = fifo_reg.vld[0];
    assign out_data_o  = fifo_reg.mem[0];
endmodule

module image_sensor_exposure_sequencer
    import sensor_seq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        master_mode_i,
    input  wire logic        subsample_i,
    input  wire logic        nondestructive_readout_bit_i,
    input  wire logic [1:0]  pulse_granularity_i,
    input  wire logic [11:0] reset_length_lines_i,
    input  wire logic [11:0] dual_slope_line_threshold_i,
    input  wire logic [11:0] triple_slope_line_threshold_i,
    input  wire logic [11:0] frame_transfer_line_threshold_i,
    input  wire logic [8:0]  start_y_i,
    input  wire logic [7:0]  window_kernel_count_i,
    input  wire logic [2:0]  exposure_pin_i,
    input  wire logic [9:0]  adc_data_i,
    input  wire logic        pixel_ready_i,
    output logic      [2:0]  exposure_pin_o,
    output logic      [2:0]  exposure_pin_oe_o,
    output logic             pixel_reset_o,
    output logic      [1:0]  extra_reset_o,
    output logic             pixel_sample_o,
    output logic             frame_transfer_o,
    output logic             frame_valid_o,
    output logic             line_valid_o,
    output logic      [9:0]  row_address_o,
    output logic             pixel_valid_o,
    output logic      [9:0]  pixel_data_o
);
`include "sensor_seq_map.svh"

    typedef struct packed {
        logic        init;      // first cycle after reset release
        logic [1:0]  div;       // input clock divider
        logic        core_en;   // one-cycle core clock tick
        seq_state_e  st;        // readout phase
        logic [7:0]  phase_cnt; // ticks left in an overhead period
        logic [9:0]  pix_cnt;   // pixels sent in the current row
        logic [11:0] line_cnt;  // lines read since overhead end
        logic [9:0]  fv_lines;  // line-valid pulses inside the frame
        logic [9:0]  row;       // row pointer, may pass the last row
        logic        pix_reset; // internal pixel reset level
        logic [1:0]  extra;     // dual / triple slope reset levels
        logic [7:0]  ds_cnt;    // dual slope pulse ticks left
        logic [7:0]  ts_cnt;    // triple slope pulse ticks left
        logic        sample;    // internal pixel sample pulse
        logic [7:0]  smp_cnt;   // sample pulse ticks left
        logic [2:0]  ind;       // integration indicators
        logic        fv;        // frame valid
        logic        lv;        // line valid
        logic [2:0]  sync1;     // first synchroniser stage
        logic [2:0]  sync2;     // second synchroniser stage
        logic [2:0]  sync3;     // delayed copy for edge detection
        logic        pr_out;    // pixel reset after suppression
        logic [1:0]  ex_out;    // extra resets after suppression
        logic [2:0]  pin_oe;    // exposure pins driven in master mode
        logic        ft_out;    // registered frame overhead flag
    } seq_s;

    seq_s seq_reg;  // registered state
    seq_s seq_next; // next state

    logic       fifo_push;  // pixel word offered to the buffer
    logic       fifo_ready; // buffer can take a word
    logic       line_end;   // last pixel of a row taken
    logic       ft_start;   // frame transfer begins this cycle
    logic [7:0] reset_len;  // reset and overhead pulse length
    logic [7:0] sample_len; // sample pulse length

    // pulse length in input clocks: 4*(unit*(granularity+1)+tail); counted
    // in clocks so the length is exact wherever the start lands
    function automatic logic [7:0] pulse_len(input logic [1:0] g,
                                             input logic [7:0] tail);
        logic [7:0] ticks; // length in core ticks, at most 50
        ticks = 8'(`PULSE_UNIT * ({6'h00, g} + 8'h01)) + tail;
        pulse_len = {ticks[5:0], 2'b00};
    endfunction

    // next-state logic for divider, readout, exposure and framing
    always_comb begin
        logic [2:0]  act;      // slave pins, active high
        logic        all_now;  // all three pins asserted
        logic        all_was;  // all three asserted a cycle earlier
        logic [11:0] step;     // line counter step
        logic [11:0] cnt_new;  // line count after this line
        logic [9:0]  row_pix;  // pixels per row
        act      = ~seq_reg.sync2;
        all_now  = &act;
        all_was  = &(~seq_reg.sync3);
        step     = subsample_i ? `LINE_STEP_SUBSAMPLE : `LINE_STEP_NORMAL;
        cnt_new  = seq_reg.line_cnt + step;
        row_pix  = {window_kernel_count_i, 2'b00};
        reset_len  = pulse_len(pulse_granularity_i, `RESET_PULSE_TAIL);
        sample_len = pulse_len(pulse_granularity_i, `SAMPLE_PULSE_TAIL);
        line_end  = 1'b0;
        ft_start  = 1'b0;
        fifo_push = 1'b0;
        seq_next  = seq_reg;

        // core tick: second input edge after release, then every fourth
        seq_next.div     = seq_reg.div + 2'h1;
        seq_next.core_en = (seq_reg.div == `CORE_DIV_FIRE);

        // the second stage is decoded, its delayed copy for the edge; the first feeds it alone
        seq_next.sync1 = exposure_pin_i;
        seq_next.sync2 = seq_reg.sync1;
        seq_next.sync3 = seq_reg.sync2;

        // after release the counter start depends on subsampling
        if (seq_reg.init) begin
            seq_next.init      = 1'b0;
            seq_next.line_cnt  = subsample_i ? `LINE_START_SUBSAMPLE
                                             : `LINE_START_NORMAL;
            seq_next.row       = {1'b0, start_y_i};
            seq_next.phase_cnt = reset_len;
        end

        // extra reset and sample pulses count down in input clocks
        begin
            if (seq_reg.ds_cnt != 8'h00) begin
                seq_next.ds_cnt = seq_reg.ds_cnt - 8'h01;
                if (seq_reg.ds_cnt == 8'h01) begin
                    seq_next.extra[0] = 1'b0;
                    seq_next.ind[1]   = 1'b1;
                end
            end
            if (seq_reg.ts_cnt != 8'h00) begin
                seq_next.ts_cnt = seq_reg.ts_cnt - 8'h01;
                if (seq_reg.ts_cnt == 8'h01) begin
                    seq_next.extra[1] = 1'b0;
                    seq_next.ind[2]   = 1'b1;
                end
            end
            if (seq_reg.smp_cnt != 8'h00) begin
                seq_next.smp_cnt = seq_reg.smp_cnt - 8'h01;
                if (seq_reg.smp_cnt == 8'h01) begin
                    seq_next.sample = 1'b0;
                    seq_next.ind    = 3'b000;
                end
            end
        end

        // readout phases
        case (seq_reg.st)
            ST_ROW_OVERHEAD: begin
                if (!seq_reg.init) begin
                    if (seq_reg.phase_cnt <= 8'h01) begin
                        seq_next.st      = ST_PIXELS;
                        seq_next.pix_cnt = 10'h000;
                        seq_next.lv      = 1'b1;
                    end else begin
                        seq_next.phase_cnt = seq_reg.phase_cnt - 8'h01;
                    end
                end
            end
            ST_PIXELS: begin
                // a full buffer stalls the row, one pixel per clock
                if (fifo_ready) begin
                    fifo_push        = 1'b1;
                    seq_next.pix_cnt = seq_reg.pix_cnt + 10'h001;
                    if (seq_reg.pix_cnt + 10'h001 >= row_pix) begin
                        line_end = 1'b1;
                    end
                end
            end
            ST_FRAME_OVERHEAD: begin
                if (!seq_reg.init) begin
                    if (seq_reg.phase_cnt <= 8'h01) begin
                        seq_next.st        = ST_ROW_OVERHEAD;
                        seq_next.phase_cnt = reset_len;
                        seq_next.line_cnt  = subsample_i
                            ? `LINE_START_SUBSAMPLE
                            : `LINE_START_NORMAL;
                        seq_next.fv        = 1'b1;
                        seq_next.fv_lines  = 10'h000;
                        seq_next.row       = {1'b0, start_y_i};
                    end else begin
                        seq_next.phase_cnt = seq_reg.phase_cnt - 8'h01;
                    end
                end
            end
            default: begin
                seq_next.st = ST_ROW_OVERHEAD;
            end
        endcase

        // end of a row: step counters and compare thresholds
        if (line_end) begin
            seq_next.st        = ST_ROW_OVERHEAD;
            seq_next.phase_cnt = reset_len;
            seq_next.lv        = 1'b0;
            // the pointer keeps running past the last real row
            seq_next.row      = seq_reg.row + step[9:0];
            seq_next.line_cnt = cnt_new;
            if (seq_reg.fv) begin
                seq_next.fv_lines = seq_reg.fv_lines + 10'h001;
                if (master_mode_i &&
                    seq_reg.fv_lines + 10'h001 == `FRAME_LINES) begin
                    seq_next.fv = 1'b0;
                end
            end
            // thresholds only matter in master mode
            if (master_mode_i) begin
                if (cnt_new == reset_length_lines_i && seq_reg.pix_reset) begin
                    seq_next.pix_reset = 1'b0;
                    seq_next.ind[0]    = 1'b1;
                end
                if (cnt_new == dual_slope_line_threshold_i) begin
                    seq_next.extra[0] = 1'b1;
                    seq_next.ds_cnt   = reset_len;
                end
                if (cnt_new == triple_slope_line_threshold_i) begin
                    seq_next.extra[1] = 1'b1;
                    seq_next.ts_cnt   = reset_len;
                end
                if (cnt_new == frame_transfer_line_threshold_i) begin
                    ft_start = 1'b1;
                end
            end
        end

        // slave mode: exposure comes straight from the decoded pins
        if (!master_mode_i) begin
            seq_next.pix_reset = act[0] && !act[1] && !act[2];
            seq_next.extra[0]  = act[1] && !act[0] && !act[2];
            seq_next.extra[1]  = act[2] && !act[0] && !act[1];
            seq_next.ds_cnt    = 8'h00;
            seq_next.ts_cnt    = 8'h00;
            seq_next.ind       = 3'b000;
            if (all_now && !all_was) begin
                ft_start = 1'b1;
            end
        end

        // frame transfer: overhead period plus the sample pulse
        if (ft_start && seq_reg.st != ST_FRAME_OVERHEAD) begin
            seq_next.st        = ST_FRAME_OVERHEAD;
            seq_next.phase_cnt = reset_len;
            seq_next.sample    = 1'b1;
            seq_next.smp_cnt   = sample_len;
            seq_next.fv        = 1'b0;
            seq_next.lv        = 1'b0;
            if (master_mode_i) begin
                seq_next.pix_reset = 1'b1; // re-arm for the next frame
            end
        end

        // nondestructive readout keeps the pixel charge untouched
        seq_next.pr_out = seq_next.pix_reset &&
                          !nondestructive_readout_bit_i;
        seq_next.ex_out = seq_next.extra &
                          {2{!nondestructive_readout_bit_i}};
        seq_next.pin_oe = {3{master_mode_i}};
        seq_next.ft_out = (seq_next.st == ST_FRAME_OVERHEAD);
    end

    // state register; settings are ports, so reset leaves them alone
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            seq_reg           <= '0;
            seq_reg.init      <= 1'b1;
            seq_reg.st        <= ST_ROW_OVERHEAD;
            seq_reg.pix_reset <= 1'b1;
            seq_reg.sync1     <= 3'b111;
            seq_reg.sync2     <= 3'b111;
            seq_reg.sync3     <= 3'b111;
        end else begin
            seq_reg <= seq_next;
        end
    end

    // pixel buffer between converter and receiver
    pixel_fifo #(
        .WIDTH(`PIXEL_WIDTH),
        .DEPTH(`PIXEL_FIFO_DEPTH)
    ) u_fifo (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .in_valid_i (fifo_push),
        .in_ready_o (fifo_ready),
        .in_data_i  (adc_data_i),
        .out_valid_o(pixel_valid_o),
        .out_ready_i(pixel_ready_i),
        .out_data_o (pixel_data_o)
    );

    assign exposure_pin_o    = seq_reg.ind;
    assign exposure_pin_oe_o = seq_reg.pin_oe;
    assign pixel_reset_o     = seq_reg.pr_out;
    assign extra_reset_o     = seq_reg.ex_out;
    assign pixel_sample_o    = seq_reg.sample;
    assign frame_transfer_o  = seq_reg.ft_out;
    assign frame_valid_o     = seq_reg.fv;
    assign line_valid_o      = seq_reg.lv;
    assign row_address_o     = seq_reg.row;

    // helper counters read only by the checks below
    logic [1:0] post_cnt; // edges since reset release, saturating
    logic [7:0] ds_high;  // ticks the dual slope pulse has been high
    logic [7:0] smp_high; // ticks the sample pulse has been high
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            post_cnt <= 2'h0;
            ds_high  <= 8'h00;
            smp_high <= 8'h00;
        end else begin
            post_cnt <= (post_cnt == 2'h3) ? post_cnt : post_cnt + 2'h1;
            ds_high  <= !seq_reg.extra[0] ? 8'h00 :
                        ds_high + 8'h01;
            smp_high <= !seq_reg.sample ? 8'h00 :
                        smp_high + 8'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_core_gap;
        !seq_reg.core_en [*3] ##1 seq_reg.core_en;
    endsequence

    a_core_div_period: assert property (
        seq_reg.core_en |=> s_core_gap)
        else $error("core tick not every fourth clock");
    a_core_first_tick: assert property (
        post_cnt == 2'h2 |-> seq_reg.core_en && $past(!seq_reg.core_en))
        else $error("first core tick not on second edge");
    a_line_cnt_load: assert property (
        seq_reg.st == ST_FRAME_OVERHEAD ##1 seq_reg.st == ST_ROW_OVERHEAD
        |-> seq_reg.line_cnt == (subsample_i ? `LINE_START_SUBSAMPLE
                                            : `LINE_START_NORMAL))
        else $error("line counter not reloaded after overhead");
    a_line_cnt_step: assert property (
        line_end |=> seq_reg.line_cnt ==
            $past(seq_reg.line_cnt) + $past(step_of_mode()))
        else $error("line counter step wrong");
    a_dual_slope_len: assert property (
        $fell(seq_reg.extra[0]) && master_mode_i |->
            $past(ds_high) == reset_len - 8'h01)
        else $error("dual slope pulse length wrong");
    a_sample_len: assert property (
        $fell(seq_reg.sample) |-> $past(smp_high) == sample_len - 8'h01)
        else $error("sample pulse length wrong");
    a_indicator_clear: assert property (
        $fell(seq_reg.sample) |-> seq_reg.ind == 3'b000)
        else $error("indicator outlives the sample pulse");
    a_frame_480_lines: assert property (
        master_mode_i && seq_reg.fv |-> seq_reg.fv_lines < `FRAME_LINES)
        else $error("frame valid beyond 480 lines");
    a_ft_start_match: assert property (
        ft_start && seq_reg.st != ST_FRAME_OVERHEAD
        |=> seq_reg.st == ST_FRAME_OVERHEAD && seq_reg.sample)
        else $error("frame transfer did not start");
    a_ndr_suppress: assert property (
        $past(nondestructive_readout_bit_i) |->
            !seq_reg.pr_out && seq_reg.ex_out == 2'b00)
        else $error("reset pulse while nondestructive");
    a_slave_pins_in: assert property (
        $past(!master_mode_i) |-> seq_reg.pin_oe == 3'b000)
        else $error("exposure pins driven in slave mode");

    function automatic logic [11:0] step_of_mode();
        step_of_mode = subsample_i ? `LINE_STEP_SUBSAMPLE
                                   : `LINE_STEP_NORMAL;
    endfunction
endmodule

// file: common/sensor_seq_map.svh
/*
 * offsets, reset values and timing counts of the exposure sequencer.
 * assumes it is included by bare name after the sequencer package.
 */
`ifndef SENSOR_SEQ_MAP_SVH
`define SENSOR_SEQ_MAP_SVH

// line counter start values after reset and after the overhead period
`define LINE_START_NORMAL    12'h001
`define LINE_START_SUBSAMPLE 12'h002
// line counter and row pointer steps
`define LINE_STEP_NORMAL     12'h001
`define LINE_STEP_SUBSAMPLE  12'h002
// lines after which frame-valid drops in master mode (480)
`define FRAME_LINES          10'h01e0
// pulse length base and tails, in core ticks (x4 input clocks)
`define PULSE_UNIT           8'h0c
`define RESET_PULSE_TAIL     8'h01
`define SAMPLE_PULSE_TAIL    8'h02
// core clock divider: input clock divided by four
`define CORE_DIV_FIRE        2'h1
// pixels per kernel, not used; the row length takes four per kernel
`define KERNEL_PIXELS        2
// pixel word width and buffer depth
`define PIXEL_WIDTH          10
`define PIXEL_FIFO_DEPTH     4

`endif

// file: common/sensor_seq_pkg.sv
/*
 * types shared by the exposure sequencer files.
 * assumes nothing of its surroundings.
 */
package sensor_seq_pkg;

    // readout phase of the sequencer
    typedef enum logic [1:0] {
        ST_ROW_OVERHEAD   = 2'b00, // row overhead before pixels
        ST_PIXELS         = 2'b01, // kernels of a row streaming out
        ST_FRAME_OVERHEAD = 2'b10  // charge moved to storage
    } seq_state_e;

endpackage

// file: tb/cam_ctrl_model.sv
/* camera controller model: stalls the pixel stream, drives exposure pins.
   assumes the sequencer samples its inputs on rising clk_i edges. */
module cam_ctrl_model (
    input  wire logic       clk_i,
    output logic            pixel_ready_o,
    output logic      [2:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pixel_ready_o = 1'b0;
        pins_o = 3'b111; // idle high, pins are active low
    end
    // refuse one word in four so the buffer fills and rows stall
    always @(negedge clk_i) pixel_ready_o <= ($urandom % 4) != 0;
    // hold one pin pattern for n cycles, changed at the falling edge
    task automatic pins(input logic [2:0] p, input int n);
        @(negedge clk_i);
        pins_o = p;
        repeat (n) @(negedge clk_i);
    endtask
endmodule

// file: tb/image_sensor_exposure_sequencer_tb.sv
/* bench of the exposure sequencer: master trials, a 480-line frame and
   slave pin decoding. assumes the controller model beside it. */
module image_sensor_exposure_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, reset_i = 1, mm = 1, sub = 0, nondestructive_readout_bit = 0;
    logic [1:0] g = 0, xr;
    logic [11:0] th [4];
    logic [8:0] sy = 0;
    logic [7:0] k = 1;
    logic [9:0] adc = 0, row, pd;
    logic [9:0] q [$];
    logic rdy, fv, lv, pr, ps, ft, pv, lvq = 0;
    logic [2:0] cam, pin_o, pin_oe, pin_w;
    logic [4:0] s, sq = 5'h1f;
    logic [6:0] w;
    int n_mismatch = 0, num_checks = 0, rows = 0, fv_rows = 0, pops = 0;
    int at [5], len [5], bs [4];
    // the shared pin level: the sequencer wins while it drives
    assign pin_w = (pin_oe & pin_o) | (~pin_oe & cam);
    assign s = {ps, ft, xr, ~pr};
    assign w = {lv, fv, s};
    image_sensor_exposure_sequencer u_image_sensor_exposure_sequencer (
        .clk_i(clk_i), .reset_i(reset_i), .master_mode_i(mm),
        .subsample_i(sub), .nondestructive_readout_bit_i(nondestructive_readout_bit),
        .pulse_granularity_i(g), .reset_length_lines_i(th[0]),
        .dual_slope_line_threshold_i(th[1]),
        .triple_slope_line_threshold_i(th[2]),
        .frame_transfer_line_threshold_i(th[3]), .start_y_i(sy),
        .window_kernel_count_i(k), .exposure_pin_i(pin_w),
        .adc_data_i(adc), .pixel_ready_i(rdy), .exposure_pin_o(pin_o),
        .exposure_pin_oe_o(pin_oe), .pixel_reset_o(pr), .extra_reset_o(xr),
        .pixel_sample_o(ps), .frame_transfer_o(ft), .frame_valid_o(fv),
        .line_valid_o(lv), .row_address_o(row), .pixel_valid_o(pv),
        .pixel_data_o(pd));
    cam_ctrl_model u_cam_ctrl_model (
        .clk_i(clk_i), .pixel_ready_o(rdy), .pins_o(cam));
    initial forever #10 clk_i = ~clk_i;
    always @(negedge clk_i) adc <= 10'($urandom);
    // rows counted by line starts, so an event never races its row end
    always @(posedge clk_i) begin
        sq <= s;
        lvq <= lv;
        // words must leave the buffer in the order they were taken
        if (reset_i) q.delete();
        else begin
            if (pv && rdy) chk(pd, q.pop_front());
            if (u_image_sensor_exposure_sequencer.fifo_push)
                q.push_back(adc);
        end
        if (reset_i || (sq[3] && !s[3])) rows <= 0;
        else if (lv && !lvq) rows <= rows + 1;
        if (reset_i || (sq[3] && !s[3])) pops <= 0;
        else if (pv && rdy) pops <= pops + 1;
        if (!fv) fv_rows <= 0;
        else if (lv && !lvq) fv_rows <= fv_rows + 1;
        for (int i = 0; i < 5; i++) begin
            if (s[i] && !sq[i]) at[i] <= rows;
            len[i] <= s[i] ? (sq[i] ? len[i] + 1 : 1) : len[i];
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_s(input int i, input logic v);
        for (int n = 0; n < 60000 && w[i] !== v; n++) @(negedge clk_i);
    endtask
    task automatic restart(input logic m);
        reset_i = 1; // settings load while held
        mm = m;
        repeat (3) @(negedge clk_i);
        chk(fv, 0);
        reset_i = 0;
    endtask
    // one master frame; reset length two is the corner at granularity 0
    task automatic trial(input logic [1:0] gv, input logic sv);
        int p;
        g = gv;
        sub = sv;
        k = 1 + $urandom % 3;
        bs[0] = gv ? 2 + $urandom % 3 : 2;
        for (int i = 1; i < 4; i++) bs[i] = bs[i-1] + 1 + $urandom % 2;
        for (int i = 0; i < 4; i++) th[i] = sv ? 2 * bs[i] : bs[i];
        restart(1);
        p = 4 * (12 * (gv + 1) + 1);
        wait_s(4, 1);
        chk(pin_o, 3'b111);
        chk(pin_oe, 3'b111);
        repeat (40) @(negedge clk_i);
        chk(pops, at[3] * 4 * k);
        wait_s(4, 0);
        repeat (3) @(negedge clk_i);
        chk(pin_o, 3'b000);
        for (int i = 0; i < 4; i++)
            chk(at[i], bs[i] - 1);
        for (int i = 1; i < 4; i++) chk(len[i], p);
        chk(len[4], p + 4);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        void'($urandom(74));
        th = '{12'h002, 12'h2bc, 12'h320, 12'h003};
        repeat (20) @(negedge clk_i);
        for (int t = 0; t < 4; t++) trial(t[1:0], t[0]);
        g = 0;
        sub = 0;
        th = '{12'h002, 12'h2bc, 12'h320, 12'h003};
        restart(1);
        wait_s(5, 1);
        th[3] = 12'h258; // frame ends by line count, not by transfer
        wait_s(5, 0);
        chk(fv_rows, 480);
        sy = 9'h1d6;
        restart(0);
        u_cam_ctrl_model.pins(3'b110, 100); // 2 us of reset
        chk(pr, 1);
        u_cam_ctrl_model.pins(3'b111, 400);
        chk({pr, fv, pin_oe}, 0);
        u_cam_ctrl_model.pins(3'b101, 8);
        chk(xr[0], 1);
        u_cam_ctrl_model.pins(3'b111, 60);
        u_cam_ctrl_model.pins(3'b011, 8);
        chk(xr[1], 1);
        u_cam_ctrl_model.pins(3'b000, 8);
        chk(ft, 1);
        u_cam_ctrl_model.pins(3'b111, 1);
        wait_s(6, 1);
        chk(row, 470);
        repeat (15) begin
            wait_s(6, 0);
            wait_s(6, 1);
        end
        chk({fv, row > 10'd480}, 2'b11);
        nondestructive_readout_bit = 1;
        u_cam_ctrl_model.pins(3'b110, 20);
        chk(pr, 0);
        end_of_test();
    end
endmodule
